// [hdl/smf_consts.vh]
// Constants for the serial memory command front end: opcodes, register map,
// status byte layout and reset values.
// Assumes inclusion by bare name from the design file.
`ifndef SMF_CONSTS_VH
`define SMF_CONSTS_VH

// Command opcodes
`define SMF_OP_SET_WRITE_LATCH 8'h06
`define SMF_OP_CLEAR_WRITE_LATCH 8'h04
`define SMF_OP_STATUS_READ 8'h05
`define SMF_OP_STATUS_WRITE 8'h01
`define SMF_OP_MEM_READ 8'h03
`define SMF_OP_FAST_READ 8'h0B
`define SMF_OP_MEM_WRITE 8'h02
`define SMF_OP_SLEEP 8'hB9
`define SMF_OP_IDENTITY_READ 8'h9F

// Status byte field positions
`define SMF_ST_WLF_BIT 1
`define SMF_ST_BP0_BIT 2
`define SMF_ST_BP1_BIT 3
`define SMF_ST_WPEN_BIT 7
`define SMF_ST_RESET 8'h00

// Software register map (byte addresses)
`define SMF_REG_STATUS 4'h0
`define SMF_REG_CTRL 4'h4
`define SMF_REG_INFO 4'h8
`define SMF_CTRL_RESET 8'h01

// Address width of the array
`define SMF_ADDR_W 15

`endif

// [hdl/smf_spi_front.v]
// Serial memory command front end: SPI slave pins sampled by CORE_CLK,
// opcode decode, address capture, write latch and 8-bit status register.
// Assumes an array beside it answering MEM_RD with MEM_RDATA in the same cycle,
// and a link clock far slower than CORE_CLK (at least 8 core cycles per phase).
//
// Behaviour
// - Input bits taken at clock rising edges, output bits changed at falling edges.
// - Clock level at select fall picks mode 0 (low) or mode 3 (high).
// - In mode 3 rising edges count only after the clock has first toggled.
// - First eight bits after select falls are the opcode; address and data follow.
// - One command per select-low period; select must rise before the next.
// - While select is high input is ignored and output floats.
// - Opcode, address and data travel most significant bit first.
// - Two address bytes; only the low 15 bits select a byte.
// - Unknown opcode: no action, ignore input until next select fall, output floats.
// - Set-write-latch is 06h, clear-write-latch is 04h.
// - Read is 03h, fast read 0Bh, write 02h.
// - Nine commands; status read 05h, status write 01h, sleep B9h.
// - Identity read is 9Fh; C3h, C2h, 5Ah, 5Bh are reserved, not accepted.
// - Write latch starts cleared after reset.
// - Set-write-latch opcode sets the latch; status bit mirrors it as 1.
// - Status write data never sets the write latch flag; select rise then clears it.
// - Latch clears at select rise ending clear-latch, status write or memory write.
// - Clear-write-latch blocks writes; status then shows the flag as 0.
// - An 8-bit status register is kept and readable by the master.
// - Hold low suspends the operation, ignores clock and select, floats output.
// - Write latch flag is status bit 1 and reads 0 after reset.
//
// The register addresses and the plain strobed port were left to the implementer.
`include "smf_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module smf_spi_front #(
	parameter ADDR_W = `SMF_ADDR_W,
	parameter [31:0] IDENTITY = 32'hA5A5_0001 // Arbitrary identity bytes
) (
	// Clock and reset
	input wire CORE_CLK,
	input wire NRST,
	// Serial pins
	input wire SPI_SCK,
	input wire SPI_CS_N,
	input wire SPI_SI,
	input wire SPI_HOLD_N,
	input wire SPI_WP_N,
	output wire SPI_SO,
	output wire SPI_SO_OE,
	// Array side
	output wire [ADDR_W-1:0] MEM_ADDR,
	output wire MEM_RD,
	output wire MEM_WR,
	output wire [7:0] MEM_WDATA,
	input wire [7:0] MEM_RDATA,
	output wire SLEEP_REQ,
	// Software register port
	input wire [3:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output wire [7:0] REG_RDATA
);

	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_OPC = 3'd1;
	localparam [2:0] ST_ADDR = 3'd2;
	localparam [2:0] ST_DUMMY = 3'd3;
	localparam [2:0] ST_DATA = 3'd4;
	localparam [2:0] ST_DONE = 3'd5;

	localparam [1:0] SRC_MEM = 2'd0;
	localparam [1:0] SRC_STATUS = 2'd1;
	localparam [1:0] SRC_ID = 2'd2;

	// Two-flop synchronisers, plus a third stage for edge detection
	reg [1:0] sck_sync_reg, cs_sync_reg, si_sync_reg, hold_sync_reg, wp_sync_reg;
	reg sck_prev_reg;
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			sck_sync_reg <= 2'b00;
			cs_sync_reg <= 2'b11;
			si_sync_reg <= 2'b00;
			hold_sync_reg <= 2'b11;
			wp_sync_reg <= 2'b11;
			sck_prev_reg <= 1'b0;
		end else begin
			sck_sync_reg <= {sck_sync_reg[0], SPI_SCK};
			cs_sync_reg <= {cs_sync_reg[0], SPI_CS_N};
			si_sync_reg <= {si_sync_reg[0], SPI_SI};
			hold_sync_reg <= {hold_sync_reg[0], SPI_HOLD_N};
			wp_sync_reg <= {wp_sync_reg[0], SPI_WP_N};
			sck_prev_reg <= sck_sync_reg[1];
		end
	end

	wire sck_s = sck_sync_reg[1];
	wire cs_n_s = cs_sync_reg[1];
	wire si_s = si_sync_reg[1];
	wire hold_ok = hold_sync_reg[1];
	wire wp_n_s = wp_sync_reg[1];

	reg [7:0] ctrl_reg;
	wire if_enable = ctrl_reg[0];

	// Select as seen by the engine; frozen while hold is low
	reg sel_reg;
	wire sel_in = ~cs_n_s & if_enable;
	wire sel_fall = hold_ok & sel_in & ~sel_reg;
	wire sel_rise = hold_ok & ~sel_in & sel_reg;
	wire active = sel_reg & hold_ok;
	// Edges come from the synchronised clock, so a link phase shorter than
	// one core cycle could be missed
	wire sck_rise = active & sck_s & ~sck_prev_reg;
	wire sck_fall = active & ~sck_s & sck_prev_reg;

	reg [2:0] state_reg;
	reg [7:0] cmd_reg;
	reg [6:0] rx_reg;
	reg [2:0] bit_cnt_reg;
	reg byte_idx_reg;
	reg armed_reg;
	reg mode3_reg;
	reg invalid_reg;
	reg [15:0] addr_reg;
	reg wlf_reg;
	reg [2:0] prot_reg; // {wpen, bp1, bp0}
	reg [7:0] tx_reg;
	reg [2:0] tx_cnt_reg;
	reg so_reg, so_oe_reg;
	reg fetch_reg;
	reg [1:0] src_reg;
	reg [1:0] id_idx_reg;
	reg [7:0] rd_buf_reg;
	reg mem_rd_reg, mem_wr_reg;
	reg [7:0] mem_wdata_reg;
	reg [ADDR_W-1:0] mem_addr_reg;
	reg sleep_reg;
	reg [7:0] reg_rdata_reg;

	// The bit arriving now joins the seven already shifted in
	wire [7:0] byte_in = {rx_reg, si_s};
	wire [7:0] status_byte = {prot_reg[2], 3'b000, prot_reg[1:0], wlf_reg, 1'b0};
	wire [ADDR_W-1:0] cur_addr = addr_reg[ADDR_W-1:0];
	wire out_cmd = (cmd_reg == `SMF_OP_MEM_READ) | (cmd_reg == `SMF_OP_FAST_READ) |
		(cmd_reg == `SMF_OP_STATUS_READ) | (cmd_reg == `SMF_OP_IDENTITY_READ);

	// Block protection of the upper quarter, upper half or whole array
	reg addr_prot;
	always @* begin
		case (prot_reg[1:0])
			2'b01: addr_prot = &cur_addr[ADDR_W-1:ADDR_W-2];
			2'b10: addr_prot = cur_addr[ADDR_W-1];
			2'b11: addr_prot = 1'b1;
			default: addr_prot = 1'b0;
		endcase
	end

	// Status writes are refused while protect enable is set and its pin is low
	wire status_locked = prot_reg[2] & ~wp_n_s;
	// Index 0 picks the top byte of the identity word
	wire [7:0] id_byte = IDENTITY[{~id_idx_reg, 3'b000} +: 8];

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			sel_reg <= 1'b0;
			state_reg <= ST_IDLE;
			cmd_reg <= 8'h00;
			rx_reg <= 7'h00;
			bit_cnt_reg <= 3'd0;
			byte_idx_reg <= 1'b0;
			armed_reg <= 1'b0;
			mode3_reg <= 1'b0;
			invalid_reg <= 1'b0;
			addr_reg <= 16'h0000;
			wlf_reg <= 1'b0;
			prot_reg <= 3'b000;
			tx_reg <= 8'h00;
			tx_cnt_reg <= 3'd0;
			so_reg <= 1'b0;
			so_oe_reg <= 1'b0;
			fetch_reg <= 1'b0;
			src_reg <= SRC_MEM;
			id_idx_reg <= 2'd0;
			rd_buf_reg <= 8'h00;
			mem_rd_reg <= 1'b0;
			mem_wr_reg <= 1'b0;
			mem_wdata_reg <= 8'h00;
			mem_addr_reg <= {ADDR_W{1'b0}};
			sleep_reg <= 1'b0;
		end else begin
			mem_rd_reg <= 1'b0;
			mem_wr_reg <= 1'b0;
			fetch_reg <= 1'b0;
			if (hold_ok)
				sel_reg <= sel_in;
			// Source data is read one cycle after the request, well before the next falling edge
			if (fetch_reg) begin
				case (src_reg)
					SRC_STATUS: rd_buf_reg <= status_byte;
					SRC_ID: rd_buf_reg <= id_byte;
					default: rd_buf_reg <= MEM_RDATA;
				endcase
			end
			// Select edges win over clock edges seen in the same cycle
			if (sel_fall) begin
				state_reg <= ST_OPC;
				mode3_reg <= sck_s;
				armed_reg <= ~sck_s;
				bit_cnt_reg <= 3'd0;
				byte_idx_reg <= 1'b0;
				tx_cnt_reg <= 3'd0;
				invalid_reg <= 1'b0;
				sleep_reg <= 1'b0;
				cmd_reg <= 8'h00;
			end else if (sel_rise) begin
				// Partial bytes are simply dropped here
				state_reg <= ST_IDLE;
				bit_cnt_reg <= 3'd0;
				byte_idx_reg <= 1'b0;
				so_oe_reg <= 1'b0;
				// Only a completed opcode may clear the latch
				if (state_reg != ST_OPC && (cmd_reg == `SMF_OP_CLEAR_WRITE_LATCH ||
					cmd_reg == `SMF_OP_STATUS_WRITE || cmd_reg == `SMF_OP_MEM_WRITE))
					wlf_reg <= 1'b0;
				if (state_reg != ST_OPC && cmd_reg == `SMF_OP_SLEEP)
					sleep_reg <= 1'b1;
			end else if (sck_fall) begin
				armed_reg <= 1'b1;
				if (state_reg == ST_DATA && out_cmd) begin
					so_oe_reg <= 1'b1;
					tx_cnt_reg <= tx_cnt_reg + 3'd1;
					if (tx_cnt_reg == 3'd0) begin
						so_reg <= rd_buf_reg[7];
						tx_reg <= {rd_buf_reg[6:0], 1'b0};
						fetch_reg <= 1'b1;
						if (src_reg == SRC_MEM) begin
							mem_rd_reg <= 1'b1;
							mem_addr_reg <= cur_addr;
							addr_reg <= {1'b0, cur_addr + {{(ADDR_W-1){1'b0}}, 1'b1}};
						end
						if (src_reg == SRC_ID)
							id_idx_reg <= id_idx_reg + 2'd1;
					end else begin
						so_reg <= tx_reg[7];
						tx_reg <= {tx_reg[6:0], 1'b0};
					end
				end
			end else if (sck_rise && armed_reg) begin
				rx_reg <= byte_in[6:0];
				bit_cnt_reg <= bit_cnt_reg + 3'd1;
				if (bit_cnt_reg == 3'd7) begin
					case (state_reg)
						ST_OPC: begin
							cmd_reg <= byte_in;
							byte_idx_reg <= 1'b0;
							case (byte_in)
								`SMF_OP_SET_WRITE_LATCH: begin
									wlf_reg <= 1'b1;
									state_reg <= ST_DONE;
								end
								`SMF_OP_CLEAR_WRITE_LATCH: state_reg <= ST_DONE;
								`SMF_OP_SLEEP: state_reg <= ST_DONE;
								`SMF_OP_STATUS_WRITE: state_reg <= ST_DATA;
								`SMF_OP_STATUS_READ: begin
									src_reg <= SRC_STATUS;
									fetch_reg <= 1'b1;
									state_reg <= ST_DATA;
								end
								`SMF_OP_IDENTITY_READ: begin
									src_reg <= SRC_ID;
									// First fetch must return the top identity byte
									id_idx_reg <= 2'd0;
									fetch_reg <= 1'b1;
									state_reg <= ST_DATA;
								end
								`SMF_OP_MEM_READ, `SMF_OP_FAST_READ, `SMF_OP_MEM_WRITE: begin
									src_reg <= SRC_MEM;
									state_reg <= ST_ADDR;
								end
								default: begin
									// Reserved codes fall here as well
									invalid_reg <= 1'b1;
									state_reg <= ST_DONE;
								end
							endcase
						end
						ST_ADDR: begin
							byte_idx_reg <= 1'b1;
							if (!byte_idx_reg) begin
								addr_reg[15:8] <= byte_in;
							end else begin
								addr_reg[7:0] <= byte_in;
								if (cmd_reg == `SMF_OP_MEM_READ) begin
									mem_rd_reg <= 1'b1;
									mem_addr_reg <= {addr_reg[ADDR_W-1:8], byte_in};
									fetch_reg <= 1'b1;
									addr_reg <= {1'b0, {addr_reg[ADDR_W-1:8], byte_in} +
										{{(ADDR_W-1){1'b0}}, 1'b1}};
									state_reg <= ST_DATA;
								end else if (cmd_reg == `SMF_OP_FAST_READ) begin
									state_reg <= ST_DUMMY;
								end else begin
									state_reg <= ST_DATA;
								end
							end
						end
						ST_DUMMY: begin
							mem_rd_reg <= 1'b1;
							mem_addr_reg <= cur_addr;
							fetch_reg <= 1'b1;
							addr_reg <= {1'b0, cur_addr + {{(ADDR_W-1){1'b0}}, 1'b1}};
							state_reg <= ST_DATA;
						end
						ST_DATA: begin
							if (cmd_reg == `SMF_OP_STATUS_WRITE) begin
								if (wlf_reg && !status_locked)
									prot_reg <= {byte_in[`SMF_ST_WPEN_BIT],
										byte_in[`SMF_ST_BP1_BIT], byte_in[`SMF_ST_BP0_BIT]};
								state_reg <= ST_DONE;
							end else if (cmd_reg == `SMF_OP_MEM_WRITE && wlf_reg && !addr_prot) begin
								// A protected address stops both the store and the increment
								mem_wr_reg <= 1'b1;
								mem_wdata_reg <= byte_in;
								mem_addr_reg <= cur_addr;
								addr_reg <= {1'b0, cur_addr + {{(ADDR_W-1){1'b0}}, 1'b1}};
							end
						end
						default: ;
					endcase
				end
			end
		end
	end

	// Software registers: status view, control, last command information
	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_reg <= `SMF_CTRL_RESET;
			reg_rdata_reg <= 8'h00;
		end else begin
			if (REG_WR && REG_ADDR == `SMF_REG_CTRL)
				ctrl_reg <= {7'h00, REG_WDATA[0]};
			if (REG_RD) begin
				case (REG_ADDR)
					`SMF_REG_STATUS: reg_rdata_reg <= status_byte;
					`SMF_REG_CTRL: reg_rdata_reg <= ctrl_reg;
					`SMF_REG_INFO: reg_rdata_reg <= {sel_reg, mode3_reg, invalid_reg,
						sleep_reg, 1'b0, state_reg};
					default: reg_rdata_reg <= 8'h00;
				endcase
			end else begin
				// Read data stand for one cycle only
				reg_rdata_reg <= 8'h00;
			end
		end
	end

	assign SPI_SO = so_reg;
	// Gated here so that hold and deselect float the line without waiting a cycle
	assign SPI_SO_OE = so_oe_reg & active & ~invalid_reg;
	assign MEM_ADDR = mem_addr_reg;
	assign MEM_RD = mem_rd_reg;
	assign MEM_WR = mem_wr_reg;
	assign MEM_WDATA = mem_wdata_reg;
	assign SLEEP_REQ = sleep_reg;
	assign REG_RDATA = reg_rdata_reg;

endmodule // smf_spi_front

`default_nettype wire

// [tb/smf_checker.sv]
// Port checker for the serial memory front end.
// Assumes a bind onto smf_spi_front; sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module smf_chk (
	// Clock and reset
	input wire CORE_CLK,
	input wire NRST,
	// Serial pins
	input wire SPI_SCK,
	input wire SPI_CS_N,
	input wire SPI_HOLD_N,
	input wire SPI_SO,
	input wire SPI_SO_OE,
	// Array and register side
	input wire MEM_RD,
	input wire MEM_WR,
	input wire SLEEP_REQ,
	input wire REG_RD,
	input wire [7:0] REG_RDATA
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);
	// Six cycles covers the select synchroniser lag
	sequence desel;
		SPI_CS_N [*6];
	endsequence
	sequence held;
		!SPI_HOLD_N [*6];
	endsequence
	so_float_a: assert property (desel |-> !SPI_SO_OE)
		else $error("output driven while deselected");
	hold_float_a: assert property (held |-> !SPI_SO_OE)
		else $error("output driven during hold");
	oe_sel_a: assert property ($rose(SPI_SO_OE) |-> !SPI_CS_N && SPI_HOLD_N)
		else $error("output enabled without select");
	so_edge_a: assert property (SPI_SO_OE && $past(SPI_SO_OE) && $changed(SPI_SO) |-> !SPI_SCK)
		else $error("output changed in clock high phase");
	rd_pulse_a: assert property (MEM_RD |=> !MEM_RD)
		else $error("read request longer than one cycle");
	wr_sel_a: assert property (MEM_WR |-> !SPI_CS_N && !MEM_RD)
		else $error("array write outside a frame");
	rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("register data outside its cycle");
	sleep_clr_a: assert property ($fell(SPI_CS_N) |-> ##[1:6] !SLEEP_REQ)
		else $error("sleep request not cleared");
endmodule // smf_chk
bind smf_spi_front smf_chk chk (.CORE_CLK(CORE_CLK), .NRST(NRST), .SPI_SCK(SPI_SCK),
	.SPI_CS_N(SPI_CS_N), .SPI_HOLD_N(SPI_HOLD_N), .SPI_SO(SPI_SO), .SPI_SO_OE(SPI_SO_OE),
	.MEM_RD(MEM_RD), .MEM_WR(MEM_WR), .SLEEP_REQ(SLEEP_REQ), .REG_RD(REG_RD),
	.REG_RDATA(REG_RDATA));
`default_nettype wire

// [tb/smf_master.sv]
// Behavioural serial bus master with 160 ns clock period.
// Assumes the bench calls xfer one frame at a time.
`timescale 1ns/1ns
`default_nettype none
module smf_master (
	// Serial pins
	output var logic sck,
	output var logic cs_n,
	output var logic si,
	input wire logic so
);
	logic [7:0] rx;
	event got;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	// Top address bit is sent as given, so the bench can test that it is dropped
	task automatic xfer(input bit m3, input int nb, input logic [39:0] tx, input int nrx);
		int i;
		sck <= m3;
		#80 cs_n <= 1'b0;
		for (i = 0; i < nb + 8 * nrx; i++) begin
			#80 sck <= 1'b0;
			si <= (i < nb) ? tx[39 - i] : 1'b0;
			#80 sck <= 1'b1;
			rx = {rx[6:0], so};
			if (i >= nb && (i - nb) % 8 == 7)
				->got;
		end
		#80 sck <= m3;
		#80 cs_n <= 1'b1;
		// A released line must not keep its last value
		si <= ~si;
		#160;
	endtask
endmodule // smf_master
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the serial memory front end.
// Assumes the master model and checker compile first.
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic clk, nrst, hold_n, reg_wr, reg_rd, rd_d;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, mem_wdata, d;
	logic [14:0] mem_addr;
	logic [15:0] a;
	logic [31:0] rng = 32'h0000_0028;
	logic [31:0] r;
	localparam logic [31:0] ID_WORD = 32'h1357_9BDF;
	logic [23:0] exp_q[$];
	logic [7:0] bad[5] = '{8'hC3, 8'hC2, 8'h5A, 8'h5B, 8'hFF};
	wire sck, cs_n, si, so, so_oe, mem_rd, mem_wr, sleep_req;
	int n_mismatch = 0, cmp_count = 0, cycles = 0, i;
	// Array model answers from the address, so reads need no storage
	wire [7:0] mem_rdata = mem_addr[7:0] ^ 8'h5A;
	smf_spi_front #(.IDENTITY(ID_WORD)) uut (.CORE_CLK(clk), .NRST(nrst),
		.SPI_SCK(sck), .SPI_CS_N(cs_n), .SPI_SI(si), .SPI_HOLD_N(hold_n), .SPI_WP_N(1'b1),
		.SPI_SO(so), .SPI_SO_OE(so_oe), .MEM_ADDR(mem_addr), .MEM_RD(mem_rd),
		.MEM_WR(mem_wr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata),
		.SLEEP_REQ(sleep_req), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
	smf_master m (.sck(sck), .cs_n(cs_n), .si(si), .so(so));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic check(input logic [23:0] got);
		logic [23:0] e;
		e = exp_q.pop_front();
		cmp_count++;
		if (got !== e) begin
			n_mismatch++;
			$display("ERROR %0t: got %h want %h", $time, got, e);
		end
	endtask
	task automatic acc(input bit w, input logic [3:0] ad, input logic [7:0] dt);
		if (!w)
			exp_q.push_back({16'h0000, dt});
		@(posedge clk);
		reg_addr <= ad;
		reg_wdata <= dt;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask
	task automatic st(input bit m3, input logic [7:0] e);
		acc(0, 4'h0, e);
		exp_q.push_back({16'h0000, e});
		m.xfer(m3, 8, {8'h05, 32'h0000_0000}, 1);
	endtask
	task automatic op(input bit m3, input logic [7:0] c);
		m.xfer(m3, 8, {c, 32'h0000_0000}, 0);
	endtask
	task automatic conclude();
		if (exp_q.size() != 0)
			n_mismatch++;
		$display("checks %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(negedge clk) begin
		if (rd_d === 1'b1)
			check({16'h0000, reg_rdata});
		if (mem_wr === 1'b1)
			check({1'b0, mem_addr, mem_wdata});
	end
	always @(posedge clk) begin
		rd_d <= reg_rd;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_mismatch++;
			conclude();
		end
	end
	always @(m.got) check({16'h0000, m.rx});
	initial begin
		{nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		hold_n = 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (10) @(posedge clk);
		hold_n <= 1'b1;
		#3;
		st(0, 8'h00);
		acc(0, 4'h4, 8'h01);
		acc(0, 4'hC, 8'h00);
		$display("test reset done");
		op(1, 8'h06);
		st(0, 8'h02);
		m.xfer(0, 16, {8'h01, 8'h06, 24'h00_0000}, 0);
		st(1, 8'h04);
		op(0, 8'h06);
		op(0, 8'h04);
		st(0, 8'h04);
		acc(1, 4'h4, 8'h00);
		op(0, 8'h06);
		acc(0, 4'h0, 8'h04);
		acc(1, 4'h4, 8'h01);
		$display("test latch done");
		r = xs();
		a = {2'b10, r[13:0]};
		r = xs();
		d = r[7:0];
		op(0, 8'h06);
		exp_q.push_back({1'b0, a[14:0], d});
		m.xfer(0, 32, {8'h02, a, d, 8'h00}, 0);
		st(0, 8'h04);
		exp_q.push_back({16'h0000, a[7:0] ^ 8'h5A});
		m.xfer(1, 32, {8'h0B, a, 16'h0000}, 1);
		exp_q.push_back({16'h0000, 8'hA5});
		exp_q.push_back({16'h0000, 8'h5A});
		m.xfer(0, 24, {8'h03, 16'hFFFF, 16'h0000}, 2);
		for (i = 0; i < 5; i++)
			exp_q.push_back({16'h0000, ID_WORD[31 - 8 * (i % 4) -: 8]});
		m.xfer(0, 8, {8'h9F, 32'h0000_0000}, 5);
		$display("test memory done");
		for (i = 0; i < 5; i++)
			m.xfer(i[0], 16, {bad[i], 8'h06, 24'h00_0000}, 0);
		st(0, 8'h04);
		m.xfer(0, 4, {8'h06, 32'h0000_0000}, 0);
		op(0, 8'h06);
		st(1, 8'h06);
		op(1, 8'hB9);
		exp_q.push_back(24'h00_0001);
		check({23'h00_0000, sleep_req});
		acc(0, 4'h8, 8'h50);
		st(0, 8'h06);
		$display("test opcodes done");
		conclude();
	end
endmodule // tb
`default_nettype wire
